// [core/flash_sec_pkg.sv]
/*
  constants for the flash security and flash clock divider block: register offsets,
  field positions, reset values, key and memory map figures and timing figures.
  assumes a 16-bit cpu address space and a 32-bit apb register bus.
*/
package flash_sec_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_CLOCK_DIVIDER = 8'h00;
  localparam logic [7:0] OFS_OPTION        = 8'h04;
  localparam logic [7:0] OFS_CONFIG        = 8'h08;
  localparam logic [7:0] OFS_PROTECT       = 8'h0c;
  localparam logic [7:0] OFS_STATUS        = 8'h10;

  // field positions
  localparam int DIVISOR_LOADED_FLAG_BIT     = 7;
  localparam int PRESCALE_BIT  = 6;
  localparam int DIV_MSB       = 5;
  localparam int BACKDOOR_KEY_ENABLE_BIT     = 7;
  localparam int NORED_BIT     = 6;
  localparam int KEY_ACCESS_SELECT_BIT    = 5;
  localparam int CONFIG_LSB    = 5;

  // reset values and masks
  localparam logic [7:0] CLOCK_DIVIDER_RESET = 8'h00;
  localparam logic [2:0] CONFIG_RESET        = 3'h0;
  localparam logic [7:0] OPTION_MASK         = 8'hc3;
  localparam logic [7:0] PROTECT_MASK        = 8'hf9;
  localparam logic [1:0] SEC_UNSECURED       = 2'h2;

  // memory map figures
  localparam logic [15:0] KEY_BASE   = 16'hffb0;
  localparam int          KEY_BYTES  = 8;
  localparam logic [15:0] RAM_FIRST  = 16'h0080;
  localparam logic [15:0] RAM_LAST   = 16'h027f;
  localparam logic [15:0] FLASH_FIRST = 16'he000;

  // timing figures
  localparam int PRESCALE_DIV   = 8;
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int PULSE_MIN_NS   = 5000;
  localparam int PULSE_MAX_NS   = 6700;
  localparam int PULSE_MIN_CYC  = (PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_MAX_CYC  = (PULSE_MAX_NS * 1000) / CLK_PERIOD_PS;

endpackage

// [core/flash_clock_gen.sv]
/*
  flash clock divider: one-cycle timing pulse every (prescale) x (divisor + 1) bus clocks.
  assumes the divisor settings stay fixed once loaded, as the write-once register ensures.
*/
`timescale 1ns/1ps
module flash_clock_gen (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // settings
  input  wire logic       run_i,
  input  wire logic       prescale_i,
  input  wire logic [5:0] divisor_i,
  // timing pulse
  output logic            tick_o
);

  logic [2:0] pre_cnt_r;
  logic [5:0] div_cnt_r;
  logic       pre_tick;

  // bus clock or bus clock divided by eight feeds the divider
  assign pre_tick = !prescale_i ||
                    (pre_cnt_r == 3'(flash_sec_pkg::PRESCALE_DIV - 1));

  // prescaler, stopped until the divisor is loaded
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt_r <= 3'h0;
    end else if (!run_i || !prescale_i) begin
      pre_cnt_r <= 3'h0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 3'h1;
    end
  end

  // main divider counts divisor+1 prescaled clocks
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_r <= 6'h00;
      tick_o    <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (!run_i) begin
        div_cnt_r <= 6'h00;
      end else if (pre_tick) begin
        if (div_cnt_r == divisor_i) begin
          div_cnt_r <= 6'h00;
          tick_o    <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 6'h01;
        end
      end
    end
  end

endmodule

// [core/flash_security.sv]
/*
  flash security gate, backdoor key check, option/protect/config registers and the
  write-once flash clock divider, reached over apb.
  assumes one cpu memory port (with fetch source and debug tags), nonvolatile values
  stable as inputs, and software that honours the key write order and spacing.
*/
`timescale 1ns/1ps
module flash_security (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic        bus_debug_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // nonvolatile contents and straps
  input  wire logic [7:0]  nonvolatile_option_byte_i,
  input  wire logic [7:0]  nonvolatile_protect_byte_i,
  input  wire logic [63:0] backdoor_key_location_i,
  input  wire logic        background_mode_select_pin_i,
  // cpu memory port
  input  wire logic        mem_req_i,
  input  wire logic        mem_write_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [7:0]  mem_wdata_i,
  input  wire logic        fetch_secure_i,
  input  wire logic        mem_debug_i,
  input  wire logic [7:0]  mem_rdata_i,
  output logic [7:0]       mem_rdata_o,
  output logic             mem_write_en_o,
  output logic             flash_cmd_write_o,
  // blank check result
  input  wire logic        blank_check_done_i,
  input  wire logic        blank_check_erased_i,
  // debug and program/erase control
  input  wire logic        debug_enable_req_i,
  output logic             debug_module_en_o,
  output logic             active_background_o,
  output logic             secure_o,
  output logic             program_erase_en_o,
  output logic [7:0]       block_protect_o,
  // program/erase timing
  input  wire logic        op_start_i,
  input  wire logic [15:0] op_pulses_i,
  output logic             flash_tick_o,
  output logic             op_busy_o,
  output logic             op_done_o
);

  // address helpers used by the gate and the key path
  function automatic logic in_secure_mem(input logic [15:0] a);
    in_secure_mem = (a >= flash_sec_pkg::FLASH_FIRST) ||
                    ((a >= flash_sec_pkg::RAM_FIRST) && (a <= flash_sec_pkg::RAM_LAST));
  endfunction

  function automatic logic in_key_range(input logic [15:0] a);
    in_key_range = (a >= flash_sec_pkg::KEY_BASE) &&
                   (a < flash_sec_pkg::KEY_BASE + 16'(flash_sec_pkg::KEY_BYTES));
  endfunction

  typedef enum logic [1:0] {KEY_IDLE, KEY_COLLECT, KEY_FULL} key_state_t;

  logic       load_pending_r;
  logic [7:0] option_r;
  logic [7:0] protect_r;
  logic [2:0] config_r;
  logic [7:0] divider_r;
  logic       unlocked_r;
  logic       active_bg_r;
  key_state_t key_state_r;
  logic [3:0] key_count_r;
  logic       key_match_r;
  logic [15:0] op_left_r;
  logic       secure;
  logic       key_access_select;
  logic       apb_wr;
  logic       apb_setup;
  logic       mem_allowed;
  logic       key_write;
  logic       key_access_select_clear;
  logic       key_good;
  logic [7:0] key_byte;
  logic [7:0] rd_byte;
  logic       rd_hit;

  // state code 1:0 is the only unsecured code; a successful unlock forces it
  assign secure  = !unlocked_r &&
                   (option_r[1:0] != flash_sec_pkg::SEC_UNSECURED);
  assign key_access_select  = config_r[flash_sec_pkg::KEY_ACCESS_SELECT_BIT - flash_sec_pkg::CONFIG_LSB];
  assign apb_wr  = psel_i && penable_i && pwrite_i;
  assign apb_setup = psel_i && !penable_i;

  // memory gate: while secured, secure code keeps full access, everything else stops at secure memory
  assign mem_allowed = !secure || !in_secure_mem(mem_addr_i) ||
                       (fetch_secure_i && !mem_debug_i);
  assign mem_rdata_o = (mem_req_i && !mem_write_i && mem_allowed) ? mem_rdata_i
                                                                  : 8'h00;

  // key writes come only from secure code with key-access set and key-enable set
  assign key_write = mem_req_i && mem_write_i && in_key_range(mem_addr_i) && key_access_select &&
                     option_r[flash_sec_pkg::BACKDOOR_KEY_ENABLE_BIT] &&
                     fetch_secure_i && !mem_debug_i;
  // a key-range write with key-access set never reaches the array or command logic
  assign mem_write_en_o = mem_req_i && mem_write_i && mem_allowed &&
                          !(in_key_range(mem_addr_i) && key_access_select);
  assign flash_cmd_write_o = mem_write_en_o && in_key_range(mem_addr_i) &&
                             program_erase_en_o;

  // stored key byte expected at the current key index
  assign key_byte = backdoor_key_location_i[8*key_count_r[2:0] +: 8];
  assign key_access_select_clear = apb_wr && (paddr_i == flash_sec_pkg::OFS_CONFIG) && key_access_select &&
                        !pwdata_i[flash_sec_pkg::KEY_ACCESS_SELECT_BIT];
  assign key_good = (key_state_r == KEY_FULL) && key_match_r &&
                    option_r[flash_sec_pkg::BACKDOOR_KEY_ENABLE_BIT];

  // option and protect bytes reload on the first edge after every reset release;
  // catching them under the asynchronous reset itself would sample a port
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      load_pending_r <= 1'b1;
      option_r       <= 8'h00;
      active_bg_r    <= 1'b0;
    end else if (load_pending_r) begin
      load_pending_r <= 1'b0;
      option_r       <= nonvolatile_option_byte_i & flash_sec_pkg::OPTION_MASK;
      active_bg_r    <= !background_mode_select_pin_i;
    end
  end

  // block protect: loaded at reset, then changed only by debug writes
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      protect_r <= 8'h00;
    end else if (load_pending_r) begin
      protect_r <= nonvolatile_protect_byte_i & flash_sec_pkg::PROTECT_MASK;
    end else if (apb_wr && bus_debug_i && (paddr_i == flash_sec_pkg::OFS_PROTECT)) begin
      protect_r <= pwdata_i[7:0] & flash_sec_pkg::PROTECT_MASK;
    end
  end

  // config bits 7:5 are plain read/write
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      config_r <= flash_sec_pkg::CONFIG_RESET;
    end else if (apb_wr && (paddr_i == flash_sec_pkg::OFS_CONFIG)) begin
      config_r <= pwdata_i[7:flash_sec_pkg::CONFIG_LSB];
    end
  end

  // write-once divider; the loaded flag is set by the first write whatever the data
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      divider_r <= flash_sec_pkg::CLOCK_DIVIDER_RESET;
    end else if (apb_wr && (paddr_i == flash_sec_pkg::OFS_CLOCK_DIVIDER) &&
                 !divider_r[flash_sec_pkg::DIVISOR_LOADED_FLAG_BIT]) begin
      divider_r <= {1'b1, pwdata_i[6:0]};
    end
  end

  // unlock lasts until reset; a failed key compare leaves it alone
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      unlocked_r <= 1'b0;
    end else if (key_access_select_clear && key_good) begin
      unlocked_r <= 1'b1;
    end else if (blank_check_done_i && blank_check_erased_i) begin
      unlocked_r <= 1'b1;
    end
  end

  // key collection: bytes must arrive in ascending order, any slip spoils the match
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      key_state_r <= KEY_IDLE;
      key_count_r <= 4'h0;
      key_match_r <= 1'b0;
    end else begin
      case (key_state_r)
        KEY_IDLE: begin
          key_count_r <= 4'h0;
          key_match_r <= 1'b1;
          if (key_access_select) begin
            key_state_r <= KEY_COLLECT;
          end
        end
        KEY_COLLECT: begin
          if (!key_access_select) begin
            key_state_r <= KEY_IDLE;
          end else if (key_write) begin
            // order check depends on software keeping the ascending sequence
            if ((mem_addr_i[2:0] != key_count_r[2:0]) || (mem_wdata_i != key_byte)) begin
              key_match_r <= 1'b0;
            end
            key_count_r <= key_count_r + 4'h1;
            if (key_count_r == 4'(flash_sec_pkg::KEY_BYTES - 1)) begin
              key_state_r <= KEY_FULL;
            end
          end
        end
        KEY_FULL: begin
          if (!key_access_select) begin
            key_state_r <= KEY_IDLE;
          end else if (key_write) begin
            key_match_r <= 1'b0; // extra bytes spoil the key
          end
        end
        default: begin
          key_state_r <= KEY_IDLE;
        end
      endcase
    end
  end

  // flash timing pulse generator, idle until the divisor is loaded
  flash_clock_gen u_clock_gen (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .run_i      (divider_r[flash_sec_pkg::DIVISOR_LOADED_FLAG_BIT]),
    .prescale_i (divider_r[flash_sec_pkg::PRESCALE_BIT]),
    .divisor_i  (divider_r[flash_sec_pkg::DIV_MSB:0]),
    .tick_o     (flash_tick_o)
  );

  // operation timer counts whole timing pulses; a start while busy is ignored
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      op_left_r <= 16'h0000;
      op_done_o <= 1'b0;
    end else begin
      op_done_o <= 1'b0;
      if (op_left_r == 16'h0000) begin
        if (op_start_i && program_erase_en_o && (op_pulses_i != 16'h0000)) begin
          op_left_r <= op_pulses_i;
        end
      end else if (flash_tick_o) begin
        op_left_r <= op_left_r - 16'h0001;
        op_done_o <= (op_left_r == 16'h0001);
      end
    end
  end

  // read mux, decoded in the setup phase so read data comes from a flop
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (paddr_i)
      flash_sec_pkg::OFS_CLOCK_DIVIDER: rd_byte = divider_r;
      flash_sec_pkg::OFS_OPTION:        rd_byte = secure ? option_r
                                          : {option_r[7:2], flash_sec_pkg::SEC_UNSECURED};
      flash_sec_pkg::OFS_CONFIG:        rd_byte = {config_r, 5'h00};
      flash_sec_pkg::OFS_PROTECT:       rd_byte = protect_r;
      flash_sec_pkg::OFS_STATUS:        rd_byte = {4'h0, op_busy_o, key_good,
                                                   active_bg_r, secure};
      default:                          rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (apb_setup) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_o <= !rd_hit;
    end
  end

  // zero-wait slave: every access phase completes at once
  assign pready_o = psel_i && penable_i;

  // outward status
  assign secure_o            = secure;
  assign debug_module_en_o   = debug_enable_req_i && !secure;
  assign active_background_o = active_bg_r;
  assign program_erase_en_o  = divider_r[flash_sec_pkg::DIVISOR_LOADED_FLAG_BIT];
  assign block_protect_o     = protect_r;
  assign op_busy_o           = (op_left_r != 16'h0000);

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  chk_gate_blocks_reads: assert property (
    (secure && mem_req_i && !mem_write_i && mem_debug_i && in_secure_mem(mem_addr_i))
      |-> (mem_rdata_o == 8'h00 && !mem_write_en_o))
    else $error("secured debug read leaked data");

  chk_secure_code_access: assert property (
    (mem_req_i && mem_write_i && fetch_secure_i && !mem_debug_i &&
     !in_key_range(mem_addr_i)) |-> mem_write_en_o)
    else $error("secure code write was blocked");

  chk_option_reload: assert property (
    $fell(load_pending_r) |->
      (option_r == (nonvolatile_option_byte_i & flash_sec_pkg::OPTION_MASK)))
    else $error("option byte not copied at reset");

  chk_sec_code_decode: assert property (
    (!unlocked_r && !load_pending_r) |->
      (secure_o == (nonvolatile_option_byte_i[1:0] != 2'h2)))
    else $error("security decode wrong");

  chk_debug_off_secure: assert property (
    secure |-> !debug_module_en_o)
    else $error("debug module enabled while secured");

  chk_backdoor_key_enable_blocks: assert property (
    (!option_r[flash_sec_pkg::BACKDOOR_KEY_ENABLE_BIT] && !unlocked_r && !blank_check_done_i)
      |=> !unlocked_r)
    else $error("unlock with key disabled");

  chk_key_not_command: assert property (
    (key_access_select && mem_req_i && mem_write_i && in_key_range(mem_addr_i))
      |-> !flash_cmd_write_o && !mem_write_en_o)
    else $error("key write reached flash command");

  chk_key_unlock: assert property (
    (key_access_select_clear && key_good) |=> (unlocked_r && !secure_o) [*2])
    else $error("good key did not unlock");

  chk_debug_key_ignored: assert property (
    (mem_debug_i && mem_req_i && mem_write_i && in_key_range(mem_addr_i))
      |-> !key_write)
    else $error("debug wrote a comparison key");

  chk_protect_app_write: assert property (
    (apb_wr && !bus_debug_i && paddr_i == flash_sec_pkg::OFS_PROTECT && !load_pending_r)
      |=> $stable(protect_r))
    else $error("application changed block protect");

  chk_blank_unlock: assert property (
    (blank_check_done_i && blank_check_erased_i) |=> !secure_o)
    else $error("blank check did not unsecure");

  chk_divider_once: assert property (
    (apb_wr && paddr_i == flash_sec_pkg::OFS_CLOCK_DIVIDER) |=>
      (divider_r[7] && (($past(divider_r[7]) && $stable(divider_r)) ||
       (!$past(divider_r[7]) && divider_r[6:0] == $past(pwdata_i[6:0])))))
    else $error("divider write-once broken");

  chk_pe_disabled: assert property (
    !divider_r[flash_sec_pkg::DIVISOR_LOADED_FLAG_BIT] |-> (!program_erase_en_o && !op_busy_o))
    else $error("program/erase enabled before divisor load");

  chk_bad_key_keeps: assert property (
    (key_access_select_clear && !key_good && !blank_check_done_i) |=> (unlocked_r == $past(unlocked_r)))
    else $error("mismatched key changed security");

  chk_op_on_tick: assert property (
    op_done_o |-> $past(flash_tick_o))
    else $error("operation ended off a timing pulse");

  cov_key_unlock: cover property (key_access_select_clear && key_good);
  cov_blank_unlock: cover property (blank_check_done_i && blank_check_erased_i && secure);
  cov_divider_load: cover property ($rose(divider_r[flash_sec_pkg::DIVISOR_LOADED_FLAG_BIT]));
  cov_op_done: cover property (op_done_o);

endmodule

// [bench/mem_model.sv]
/*
  byte memory standing behind the security gate, answering cpu accesses at once.
  assumes address and write data come straight from the cpu port, with the gate's own write enable.
*/
`timescale 1ns/1ps
module mem_model (
  // clock
  input  wire logic        clock_i,
  // gated cpu side
  input  wire logic        req_i,
  input  wire logic        write_en_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic [7:0]       rdata_o
);
  logic [7:0] store_r [0:1023];
  logic [7:0] last_r;
  // preset pattern so a blocked read of zero cannot pass by luck
  initial begin
    for (int i = 0; i < 1024; i++) store_r[i] = i[7:0] ^ 8'h5a;
    last_r = 8'h00;
  end
  // writes land only when the gate lets them through
  always @(posedge clock_i) begin
    if (write_en_i) store_r[addr_i[9:0]] <= wdata_i;
    if (req_i) last_r <= store_r[addr_i[9:0]];
  end
  // an idle port shows the inverse of the last value, never a held copy
  assign rdata_o = req_i ? store_r[addr_i[9:0]] : ~last_r;
endmodule

// [bench/tb_top.sv]
/*
  self-checking bench for the flash security block: apb master, cpu port driver, memory model.
  assumes zero-wait apb and combinational memory gating as handed over.
*/
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic e;} row_t;
  logic clock_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, bdbg = 0;
  logic [7:0] paddr = 0, nonvolatile_option_byte = 8'h83, mwd = 0, mr, rdm;
  logic [31:0] pwdata = 0, rd, prdata_o;
  logic mreq = 0, mw = 0, fsec = 0, mdbg = 0, bdone = 0, bers = 0, dreq = 1, ostart = 0;
  logic bkgd = 0;
  logic er, mwe, mcmd, pready_o, pslverr_o, mwe_o, cmd_o, dben_o, abg_o, secure_o;
  logic pe_en_o, tick_o, busy_o, done_o;
  logic [7:0] prot_o, mrd_o;
  logic [15:0] maddr = 0;
  logic [63:0] key = 64'h0123_4567_89ab_cdef;
  int miscompares = 0, compares = 0, n, k;
  row_t rows [6] = '{'{8'h00, 8'h00, 0}, '{8'h04, 8'h83, 0}, '{8'h08, 8'h00, 0},
                     '{8'h0c, 8'hd8, 0}, '{8'h10, 8'h03, 0}, '{8'h14, 8'h00, 1}};
  // free-running bus clock, 8 ns period
  always #4 clock_i = ~clock_i;
  flash_security dut_u (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .bus_debug_i(bdbg),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .nonvolatile_option_byte_i(nonvolatile_option_byte), .nonvolatile_protect_byte_i(8'hde),
    .backdoor_key_location_i(key), .background_mode_select_pin_i(bkgd), .mem_req_i(mreq),
    .mem_write_i(mw), .mem_addr_i(maddr), .mem_wdata_i(mwd), .fetch_secure_i(fsec),
    .mem_debug_i(mdbg), .mem_rdata_i(rdm), .mem_rdata_o(mrd_o), .mem_write_en_o(mwe_o),
    .flash_cmd_write_o(cmd_o), .blank_check_done_i(bdone), .blank_check_erased_i(bers),
    .debug_enable_req_i(dreq), .debug_module_en_o(dben_o), .active_background_o(abg_o),
    .secure_o(secure_o), .program_erase_en_o(pe_en_o), .block_protect_o(prot_o),
    .op_start_i(ostart), .op_pulses_i(16'h0003), .flash_tick_o(tick_o), .op_busy_o(busy_o),
    .op_done_o(done_o));
  mem_model mem_u (.clock_i(clock_i), .req_i(mreq), .write_en_i(mwe_o), .addr_i(maddr),
    .wdata_i(mwd), .rdata_o(rdm));
  task print_verdict;
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one apb transfer, held until pready is seen at a rising edge
  task apb(input logic w, input logic dbg, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    {psel, penable, pwrite, bdbg, paddr, pwdata} <= {1'b1, 1'b0, w, dbg, a, d};
    @(posedge clock_i);
    penable <= 1;
    k = 0;
    @(posedge clock_i);
    while (pready_o !== 1'b1 && k < 20) begin
      @(posedge clock_i);
      k++;
    end
    if (k >= 20) miscompares++;
    rd = prdata_o;
    er = pslverr_o;
    {psel, penable} <= 2'b00;
    // let the access edge settle before anyone looks at register outputs
    #1;
  endtask
  // one cpu access lasting one cycle, with an idle cycle before the next
  task mem(input logic w, input logic s, input logic dbg, input logic [15:0] a,
           input logic [7:0] d);
    @(posedge clock_i);
    {mreq, mw, fsec, mdbg, maddr, mwd} <= {1'b1, w, s, dbg, a, d};
    #1;
    {mr, mwe, mcmd} = {mrd_o, mwe_o, cmd_o};
    @(posedge clock_i);
    mreq <= 0;
  endtask
  // cycles between two flash timing pulses, sampled on rising edges only
  task tick_gap(output int g);
    @(posedge clock_i);
    g = 0;
    while (tick_o !== 1'b1 && g < 300) begin
      @(posedge clock_i);
      g++;
    end
    g = 1;
    @(posedge clock_i);
    while (tick_o !== 1'b1 && g < 300) begin
      @(posedge clock_i);
      g++;
    end
  endtask
  task key_seq(input logic [63:0] kv, input logic dbg);
    apb(1, 0, 8'h08, 32'h20);
    for (int i = 0; i < 8; i++) mem(1, 1, dbg, 16'hffb0 + i[15:0], kv[8*i+:8]);
    apb(1, 0, 8'h08, 32'h00);
    @(posedge clock_i);
    #1;
  endtask
  task do_reset(input logic [7:0] opt);
    @(posedge clock_i);
    rst_i <= 1;
    nonvolatile_option_byte <= opt;
    bkgd  <= opt[2];
    repeat (3) @(posedge clock_i);
    rst_i <= 0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  // watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    print_verdict();
  end
  initial begin
    do_reset(8'h83);
    foreach (rows[i]) begin
      apb(0, 0, rows[i].a, 32'h0);
      chk(rd, {24'h0, rows[i].d});
      chk(er, rows[i].e);
    end
    chk({dben_o, abg_o, pe_en_o}, 3'b010);
    mem(1, 0, 1, 16'h0100, 8'h11);
    chk(mwe, 0);
    mem(0, 0, 0, 16'h0100, 8'h00);
    chk(mr, 8'h00);
    mem(1, 1, 0, 16'h0100, 8'h33);
    mem(0, 1, 0, 16'h0100, 8'h00);
    chk(mr, 8'h33);
    apb(1, 0, 8'h0c, 32'hff);
    chk(prot_o, 8'hd8);
    apb(1, 1, 8'h0c, 32'h21);
    chk(prot_o, 8'h21);
    apb(1, 0, 8'h00, 32'h41);
    apb(1, 0, 8'h00, 32'h00);
    apb(0, 0, 8'h00, 32'h0);
    chk(rd, 32'hc1);
    chk(pe_en_o, 1);
    mem(1, 1, 0, 16'hffb0, 8'h00);
    chk(mcmd, 1);
    tick_gap(n);
    chk(n, 16);
    ostart <= 1;
    @(posedge clock_i);
    ostart <= 0;
    #1;
    chk(busy_o, 1);
    n = 0;
    k = 0;
    while (done_o !== 1'b1 && k < 500) begin
      if (tick_o === 1'b1) n++;
      @(posedge clock_i);
      k++;
    end
    chk(n, 3);
    key_seq(~key, 0);
    chk(secure_o, 1);
    key_seq(key, 1);
    chk(secure_o, 1);
    key_seq(key, 0);
    chk(secure_o, 0);
    chk(dben_o, 1);
    apb(0, 0, 8'h04, 32'h0);
    chk(rd, 32'h82);
    for (int c = 0; c < 4; c++) begin
      do_reset({5'h10, c[0], c[1:0]});
      chk(secure_o, c != 2);
      chk(abg_o, !c[0]);
    end
    do_reset(8'h03);
    key_seq(key, 0);
    chk(secure_o, 1);
    @(posedge clock_i);
    {bdone, bers} <= 2'b11;
    @(posedge clock_i);
    {bdone, bers} <= 2'b00;
    @(posedge clock_i);
    #1;
    chk(secure_o, 0);
    do_reset(8'h83);
    chk(secure_o, 1);
    apb(1, 0, 8'h00, 32'h03);
    tick_gap(n);
    chk(n, 4);
    print_verdict();
  end
endmodule
